// ==== rtl/dmvt_consts.svh ====
`ifndef DMVT_CONSTS_SVH
`define DMVT_CONSTS_SVH

// ==========================================
// Mode codes
`define DMVT_MODE_NONE 8'h00
`define DMVT_MODE_PV 8'h03
`define DMVT_MODE_PT 8'h04
`define DMVT_MODE_HM 8'h06

// ==========================================
// Bit positions
`define DMVT_CW_HOME_START 4
`define DMVT_CW_HALT 8
`define DMVT_SW_TARGET 10
`define DMVT_SW_HOME_ATT 12
`define DMVT_SW_HOME_ERR 13
`define DMVT_POL_VEL_BIT 6
`define DMVT_SUBMODE_BIT 5

// ==========================================
// Values
`define DMVT_PROF_TRAP 16'h0000
`define DMVT_PROF_JERK 16'h0003
`define DMVT_TQ_FULL 16'h03e8

// ==========================================
// Timing
`define DMVT_CLK_PERIOD_NS 4
`define DMVT_MS_NS 1000000
`define DMVT_MS_CYCLES (`DMVT_MS_NS / `DMVT_CLK_PERIOD_NS)
`define DMVT_CLK_HZ (1000000000 / `DMVT_CLK_PERIOD_NS)

`endif

// ==== rtl/dmvt_pkg.sv ====
`default_nettype none
package dmvt_pkg;
	// ==========================================
	// Homing sequencer states
	typedef enum logic [5:0] {
		DMVT_H_IDLE = 6'h01,
		DMVT_H_RUN = 6'h02,
		DMVT_H_CONF = 6'h04,
		DMVT_H_DONE = 6'h08,
		DMVT_H_ERRMV = 6'h10,
		DMVT_H_ERRST = 6'h20
	} dmvt_hstate_t;
	typedef logic [7:0] dmvt_mode_t;
endpackage : dmvt_pkg
`default_nettype wire

// ==== rtl/dmvt_window.sv ====
`default_nettype none
module dmvt_window import dmvt_pkg::*; #(
	parameter int TW = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic in_window,
	input wire logic ms_tick,
	input wire logic [TW-1:0] time_ms,
	output logic reached_q
);
	if (TW < 1) begin : g_bad_tw
		$error("dmvt_window: TW must be at least 1");
	end

	logic [TW-1:0] cnt_q, cnt_d;
	logic reached_d;

	// ==========================================
	// Window dwell timer
	always_comb begin
		cnt_d = cnt_q;
		reached_d = reached_q;
		if (!in_window) begin
			cnt_d = '0;
			reached_d = 1'b0;
		end else if (cnt_q >= time_ms) begin
			reached_d = 1'b1;
		end else if (ms_tick) begin
			cnt_d = cnt_q + {{(TW-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			reached_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			reached_q <= reached_d;
		end
	end

	// ==========================================
	// Checks
	AST_WIN_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
		!in_window |=> !reached_q && cnt_q == '0)
		else $error("reached flag survived leaving the window");
	AST_WIN_TIME: assert property (@(posedge clock) disable iff (!rstn)
		$rose(reached_q) |-> $past(cnt_q) >= $past(time_ms) && $past(in_window))
		else $error("reached flag set before dwell time");
endmodule : dmvt_window
`default_nettype wire

// ==== rtl/dmvt_top.sv ====
`include "dmvt_consts.svh"
`default_nettype none
module dmvt_top import dmvt_pkg::*; #(
	parameter int MS_CYCLES = `DMVT_MS_CYCLES,
	parameter int CLK_HZ = `DMVT_CLK_HZ
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] mode_sel,
	input wire logic [15:0] ctrl_word,
	input wire logic oper_enabled,
	input wire logic signed [31:0] target_vel,
	input wire logic signed [31:0] vel_demand,
	input wire logic signed [31:0] vel_actual,
	input wire logic [31:0] vel_max,
	input wire logic [31:0] vel_window,
	input wire logic [15:0] vel_window_time,
	input wire logic [7:0] polarity,
	input wire logic [15:0] profile_type,
	input wire logic signed [15:0] target_torque,
	input wire logic signed [15:0] torque_actual,
	input wire logic [15:0] torque_max,
	input wire logic [31:0] torque_slope,
	input wire logic [15:0] torque_window,
	input wire logic [15:0] torque_window_time,
	input wire logic [15:0] peak_duration,
	input wire logic [15:0] peak_torque,
	input wire logic [31:0] submode,
	input wire logic [31:0] home_switch_speed,
	input wire logic [31:0] home_index_speed,
	input wire logic [31:0] home_accel,
	input wire logic signed [31:0] home_offset,
	input wire logic home_found,
	input wire logic home_at_target,
	input wire logic homing_error,
	input wire logic search_index,
	input wire logic limit_pos_pin,
	input wire logic limit_neg_pin,
	input wire logic signed [31:0] position_actual,
	input wire logic [31:0] tol_band,
	input wire logic fault_reset,
	input wire logic [15:0] current_actual,
	input wire logic [15:0] block_min_current,
	input wire logic [15:0] block_detect_time,
	input wire logic [15:0] block_period,
	output logic [7:0] active_mode_q,
	output logic mode_reject,
	output logic ramp_enable_q,
	output logic jerk_limited_q,
	output logic signed [31:0] vel_ramp_target_q,
	output logic signed [15:0] torque_demand_q,
	output logic speed_limit_en_q,
	output logic field_weak_en_q,
	output logic [31:0] home_speed_q,
	output logic [31:0] home_accel_q,
	output logic signed [31:0] position_preset_q,
	output logic position_preset_pulse_q,
	output logic [15:0] status_bits_q,
	output logic limit_fault_q,
	output logic block_detected_q,
	output logic drive_block_q,
	output logic block_done_q
);
	if (MS_CYCLES < 1 || CLK_HZ < 1) begin : g_bad_par
		$error("dmvt_top: MS_CYCLES and CLK_HZ must be positive");
	end

	localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
	localparam logic [32:0] HZ = 33'(CLK_HZ);

	// ==========================================
	// Millisecond tick
	logic [31:0] ms_cnt_q, ms_cnt_d;
	logic ms_tick;
	assign ms_tick = (ms_cnt_q == MS_LAST);
	always_comb begin
		ms_cnt_d = ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
	end

	// ==========================================
	// Mode select
	logic mode_ok, is_pv, is_pt, is_hm, halt;
	dmvt_mode_t mode_d;
	assign mode_ok = (mode_sel == `DMVT_MODE_PV) || (mode_sel == `DMVT_MODE_PT)
		|| (mode_sel == `DMVT_MODE_HM);
	assign mode_reject = !mode_ok && (mode_sel != active_mode_q);
	assign is_pv = (active_mode_q == `DMVT_MODE_PV);
	assign is_pt = (active_mode_q == `DMVT_MODE_PT);
	assign is_hm = (active_mode_q == `DMVT_MODE_HM);
	assign halt = ctrl_word[`DMVT_CW_HALT];
	always_comb begin
		mode_d = mode_ok ? mode_sel : active_mode_q;
	end

	// ==========================================
	// Profile velocity
	logic signed [32:0] tv_s, tv_c, vmax_s, vel_err, vel_abs;
	logic vel_in_win, vel_reached, vel_still, jerk_d;
	assign vmax_s = $signed({1'b0, vel_max});
	always_comb begin
		tv_s = {target_vel[31], target_vel};
		if (polarity[`DMVT_POL_VEL_BIT]) begin
			tv_s = -tv_s;
		end
		tv_c = tv_s;
		if (tv_s > vmax_s) begin
			tv_c = vmax_s;
		end else if (tv_s < -vmax_s) begin
			tv_c = -vmax_s;
		end
		if (halt) begin // Halt drives the ramp to standstill
			tv_c = '0;
		end
		vel_err = {vel_demand[31], vel_demand} - {vel_actual[31], vel_actual};
		vel_abs = vel_err[32] ? -vel_err : vel_err;
		jerk_d = jerk_limited_q;
		if (profile_type == `DMVT_PROF_JERK) begin
			jerk_d = 1'b1;
		end else if (profile_type == `DMVT_PROF_TRAP) begin
			jerk_d = 1'b0;
		end
	end
	assign vel_in_win = (vel_abs <= $signed({1'b0, vel_window}));
	assign vel_still = (vel_actual == 32'sh0000_0000);

	dmvt_window #(.TW(16)) u_vel_win (
		.clock(clock),
		.rstn(rstn),
		.in_window(vel_in_win && is_pv),
		.ms_tick(ms_tick),
		.time_ms(vel_window_time),
		.reached_q(vel_reached)
	);

	// ==========================================
	// Profile torque
	logic signed [16:0] tq_lim, tq_t, dem_s, dem_n, tq_err, tq_abs;
	logic [15:0] lim_raw;
	logic [32:0] acc_q, acc_d, acc_sum;
	logic signed [15:0] dem_d;
	logic tq_reached, tq_run;
	assign tq_run = is_pt && oper_enabled;
	always_comb begin
		lim_raw = (peak_duration != 16'h0000) ? peak_torque
			: `DMVT_TQ_FULL;
		if (torque_max < lim_raw) begin
			lim_raw = torque_max;
		end
		tq_lim = $signed({1'b0, lim_raw});
		tq_t = (tq_run && !halt) ? {target_torque[15], target_torque}
			: 17'sh0;
		if (tq_t > tq_lim) begin
			tq_t = tq_lim;
		end else if (tq_t < -tq_lim) begin
			tq_t = -tq_lim;
		end
		dem_s = {torque_demand_q[15], torque_demand_q};
		dem_n = dem_s;
		acc_sum = acc_q + {1'b0, torque_slope};
		acc_d = '0;
		if (dem_s != tq_t) begin
			acc_d = acc_sum;
			if (acc_sum >= HZ) begin
				acc_d = acc_sum - HZ;
				dem_n = (dem_s > tq_t) ? dem_s - 17'sh1 : dem_s + 17'sh1;
			end
		end
		if (dem_n > tq_lim) begin
			dem_n = tq_lim;
		end else if (dem_n < -tq_lim) begin
			dem_n = -tq_lim;
		end
		dem_d = dem_n[15:0];
		tq_err = {torque_actual[15], torque_actual} - tq_t;
		tq_abs = tq_err[16] ? -tq_err : tq_err;
	end

	dmvt_window #(.TW(16)) u_tq_win (
		.clock(clock),
		.rstn(rstn),
		.in_window(is_pt && tq_abs <= $signed({1'b0, torque_window})),
		.ms_tick(ms_tick),
		.time_ms(torque_window_time),
		.reached_q(tq_reached)
	);

	// ==========================================
	// Homing sequencer
	dmvt_hstate_t hst_q, hst_d;
	logic start_q, start_rise, home_bit;
	logic signed [31:0] preset_d;
	logic preset_pulse_d;
	assign home_bit = ctrl_word[`DMVT_CW_HOME_START];
	assign start_rise = home_bit && !start_q && is_hm;
	always_comb begin
		hst_d = hst_q;
		preset_d = position_preset_q;
		preset_pulse_d = 1'b0;
		unique case (hst_q)
			DMVT_H_IDLE: begin
				if (start_rise) begin
					hst_d = DMVT_H_RUN;
				end
			end
			DMVT_H_RUN, DMVT_H_CONF: begin
				if (!home_bit) begin
					hst_d = DMVT_H_IDLE;
				end else if (homing_error) begin
					hst_d = DMVT_H_ERRMV;
				end else if (hst_q == DMVT_H_RUN && home_found) begin
					hst_d = DMVT_H_CONF;
					preset_d = home_offset;
					preset_pulse_d = 1'b1;
				end else if (hst_q == DMVT_H_CONF && home_at_target) begin
					hst_d = DMVT_H_DONE;
				end
			end
			DMVT_H_ERRMV: begin
				if (vel_still) begin
					hst_d = DMVT_H_ERRST;
				end
			end
			DMVT_H_DONE, DMVT_H_ERRST: begin
				if (start_rise) begin
					hst_d = DMVT_H_RUN;
				end
			end
			default: hst_d = DMVT_H_IDLE;
		endcase
		if (!is_hm) begin // Leaving the mode abandons the sequence
			hst_d = DMVT_H_IDLE;
		end
	end

	// ==========================================
	// Limit switch tolerance
	logic [1:0] lim_pin, lim_f_q, lim_f_d, lim_prev_q;
	logic [1:0] lim_s1_q, lim_s2_q, lim_s3_q;
	logic signed [31:0] lim_pos_q, lim_pos_d;
	logic signed [32:0] lim_err, lim_abs;
	logic tol_exceed, fault_d;
	assign lim_pin = {limit_neg_pin, limit_pos_pin};
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				lim_s1_q[i] <= 1'b0;
				lim_s2_q[i] <= 1'b0;
				lim_s3_q[i] <= 1'b0;
			end else begin
				lim_s1_q[i] <= lim_pin[i];
				lim_s2_q[i] <= lim_s1_q[i];
				lim_s3_q[i] <= lim_s2_q[i];
			end
		end
		// Only a level seen twice in a row counts, so a glitch is ignored
		assign lim_f_d[i] = (lim_s2_q[i] == lim_s3_q[i]) ? lim_s2_q[i]
			: lim_f_q[i];
	end
	always_comb begin
		lim_pos_d = lim_pos_q;
		if (|(lim_f_q & ~lim_prev_q)) begin
			lim_pos_d = position_actual;
		end
		lim_err = {position_actual[31], position_actual}
			- {lim_pos_q[31], lim_pos_q};
		lim_abs = lim_err[32] ? -lim_err : lim_err;
		tol_exceed = (|lim_f_q) && (|lim_prev_q)
			&& (lim_abs > $signed({1'b0, tol_band}));
		fault_d = limit_fault_q;
		if (fault_reset) begin
			fault_d = 1'b0;
		end
		if (tol_exceed) begin // Set wins over a clear in the same cycle
			fault_d = 1'b1;
		end
	end

	// ==========================================
	// Block detection
	logic [15:0] blk_cnt_q, blk_cnt_d;
	logic blk_det_d, drive_d, blk_done_d, blk_en, above;
	assign blk_en = is_hm && (hst_q == DMVT_H_RUN || hst_q == DMVT_H_CONF);
	assign above = current_actual > block_min_current;
	always_comb begin
		blk_cnt_d = blk_cnt_q;
		blk_det_d = 1'b0;
		drive_d = drive_block_q;
		blk_done_d = 1'b0;
		if (!blk_en) begin
			blk_cnt_d = '0;
			drive_d = 1'b0;
		end else if (drive_block_q) begin
			if (blk_cnt_q >= block_period) begin
				drive_d = 1'b0;
				blk_done_d = 1'b1;
				blk_cnt_d = '0;
			end else if (ms_tick) begin
				blk_cnt_d = blk_cnt_q + 16'h0001;
			end
		end else if (!above) begin
			blk_cnt_d = '0;
		end else if (blk_cnt_q >= block_detect_time) begin
			blk_det_d = 1'b1;
			drive_d = 1'b1;
			blk_cnt_d = '0;
		end else if (ms_tick) begin
			blk_cnt_d = blk_cnt_q + 16'h0001;
		end
	end

	// ==========================================
	// Status and outputs
	logic [15:0] status_d;
	logic pure_tq;
	assign pure_tq = submode[`DMVT_SUBMODE_BIT];
	always_comb begin
		status_d = 16'h0000;
		if (is_pv) begin
			status_d[`DMVT_SW_TARGET] = halt ? vel_still : vel_reached;
		end else if (is_pt) begin
			status_d[`DMVT_SW_TARGET] = halt ? vel_still : tq_reached;
		end else if (is_hm) begin
			status_d[`DMVT_SW_TARGET] = (hst_q == DMVT_H_IDLE)
				|| (hst_q == DMVT_H_DONE) || (hst_q == DMVT_H_ERRST);
			status_d[`DMVT_SW_HOME_ATT] = (hst_q == DMVT_H_CONF)
				|| (hst_q == DMVT_H_DONE);
			status_d[`DMVT_SW_HOME_ERR] = (hst_q == DMVT_H_ERRMV)
				|| (hst_q == DMVT_H_ERRST);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_q <= '0;
			active_mode_q <= `DMVT_MODE_NONE;
			ramp_enable_q <= 1'b0;
			jerk_limited_q <= 1'b0;
			vel_ramp_target_q <= '0;
			acc_q <= '0;
			torque_demand_q <= '0;
			speed_limit_en_q <= 1'b0;
			field_weak_en_q <= 1'b0;
			hst_q <= DMVT_H_IDLE;
			start_q <= 1'b0;
			home_speed_q <= '0;
			home_accel_q <= '0;
			position_preset_q <= '0;
			position_preset_pulse_q <= 1'b0;
			lim_f_q <= '0;
			lim_prev_q <= '0;
			lim_pos_q <= '0;
			limit_fault_q <= 1'b0;
			blk_cnt_q <= '0;
			block_detected_q <= 1'b0;
			drive_block_q <= 1'b0;
			block_done_q <= 1'b0;
			status_bits_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_d;
			active_mode_q <= mode_d;
			ramp_enable_q <= oper_enabled && !limit_fault_q
				&& (is_pv || is_pt || is_hm);
			jerk_limited_q <= jerk_d;
			vel_ramp_target_q <= is_pv ? tv_c[31:0] : 32'sh0000_0000;
			acc_q <= acc_d;
			torque_demand_q <= dem_d;
			speed_limit_en_q <= is_pt && !pure_tq;
			field_weak_en_q <= is_pt && !pure_tq;
			hst_q <= hst_d;
			start_q <= home_bit;
			home_speed_q <= search_index ? home_index_speed
				: home_switch_speed;
			home_accel_q <= home_accel;
			position_preset_q <= preset_d;
			position_preset_pulse_q <= preset_pulse_d;
			lim_f_q <= lim_f_d;
			lim_prev_q <= lim_f_q;
			lim_pos_q <= lim_pos_d;
			limit_fault_q <= fault_d;
			blk_cnt_q <= blk_cnt_d;
			block_detected_q <= blk_det_d;
			drive_block_q <= drive_d;
			block_done_q <= blk_done_d;
			status_bits_q <= status_d;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	logic vel_in_range;
	logic [15:0] dem_abs;
	assign vel_in_range = !tv_s[32] ? tv_s <= vmax_s : tv_s >= -vmax_s;
	assign dem_abs = torque_demand_q[15] ? 16'(-torque_demand_q)
		: torque_demand_q;

	AST_MODE_KEEP: assert property (!mode_ok |=> $stable(active_mode_q))
		else $error("unsupported mode code was accepted");
	AST_VEL_BIT: assert property (is_pv && !halt && !vel_in_win
		##1 is_pv && !halt |=> !status_bits_q[`DMVT_SW_TARGET])
		else $error("velocity reached shown outside window");
	AST_POLARITY: assert property (is_pv && !halt && vel_in_range
		&& polarity[`DMVT_POL_VEL_BIT] |=> vel_ramp_target_q
		== -$past(target_vel))
		else $error("polarity inversion not applied");
	AST_JERK: assert property (profile_type == `DMVT_PROF_JERK
		|=> jerk_limited_q)
		else $error("jerk-limited ramp not selected");
	AST_TQ_LIMIT: assert property (dem_abs <= $past(lim_raw))
		else $error("torque demand beyond limit");
	AST_HOME_START: assert property (hst_q == DMVT_H_IDLE && start_rise
		|=> hst_q == DMVT_H_RUN)
		else $error("homing did not start");
	AST_HOME_STOP: assert property ((hst_q == DMVT_H_RUN
		|| hst_q == DMVT_H_CONF) && !home_bit |=> hst_q == DMVT_H_IDLE)
		else $error("homing not interrupted by clearing start bit");
	AST_HOME_ERR: assert property (hst_q == DMVT_H_ERRMV
		|=> status_bits_q[`DMVT_SW_HOME_ERR] && !status_bits_q[`DMVT_SW_TARGET])
		else $error("homing error while turning shows wrong code");
	AST_LIM_FAULT: assert property (tol_exceed |=> limit_fault_q ##1
		!ramp_enable_q)
		else $error("tolerance band overrun did not fault");
	AST_BLOCK: assert property ($rose(block_detected_q)
		&& block_period != 16'h0000 |-> drive_block_q [*2])
		else $error("block not driven after detection");
	AST_SUBMODE: assert property (is_pt && pure_tq |=> !field_weak_en_q
		&& !speed_limit_en_q)
		else $error("pure torque still allows speed limit");

	COV_VEL_REACHED: cover property (is_pv && $rose(vel_reached));
	COV_TQ_REACHED: cover property (is_pt && $rose(tq_reached));
	COV_HOME_DONE: cover property (hst_q == DMVT_H_CONF ##1 hst_q == DMVT_H_DONE);
	COV_BLOCK_DONE: cover property (block_done_q);
	COV_LIM_FAULT: cover property ($rose(limit_fault_q));
endmodule : dmvt_top
`default_nettype wire

// ==== sim/dmvt_host.sv ====
`default_nettype none
// ==========================================
// Host controller model: writes mode and control word
module dmvt_host import dmvt_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] want_mode,
	input wire logic want_home,
	input wire logic want_halt,
	output logic [7:0] mode_sel,
	output logic [15:0] ctrl_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registered like a fieldbus write, so objects land one cycle late
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_sel <= 8'h00;
			ctrl_word <= 16'h0000;
		end else begin
			mode_sel <= want_mode;
			ctrl_word <= {7'h00, want_halt, 3'h0, want_home, 4'h0};
		end
	end
endmodule : dmvt_host
`default_nettype wire

// ==== sim/dmvt_top_tb.sv ====
`include "dmvt_consts.svh"
`default_nettype none
module dmvt_top_tb import dmvt_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Signals
	logic clock = 1'b0, rstn = 1'b0, oper_enabled = '0, home_found = '0;
	logic home_at_target = '0, homing_error = '0, search_index = '0;
	logic limit_pos_pin = '0, limit_neg_pin = '0, fault_reset = '0;
	logic want_home = '0, want_halt = '0;
	logic [7:0] want_mode = '0, polarity = '0, mode_sel, active_mode_q;
	logic [15:0] ctrl_word, status_bits_q, profile_type = '0;
	logic [15:0] torque_max = '0, torque_window = '0;
	logic [15:0] torque_window_time = '0, vel_window_time = '0;
	logic [15:0] peak_duration = '0, peak_torque = '0, current_actual = '0;
	logic [15:0] block_min_current = '0, block_detect_time = '0;
	logic [15:0] block_period = '0;
	logic signed [15:0] target_torque = '0, torque_actual = '0;
	logic signed [15:0] torque_demand_q;
	logic [31:0] vel_max = '0, vel_window = '0, torque_slope = '0;
	logic [31:0] submode = '0, home_switch_speed = '0, home_accel = '0;
	logic [31:0] home_index_speed = '0, tol_band = '0;
	logic [31:0] home_speed_q, home_accel_q;
	logic signed [31:0] target_vel = '0, vel_demand = '0, vel_actual = '0;
	logic signed [31:0] home_offset = '0, position_actual = '0;
	logic signed [31:0] vel_ramp_target_q, position_preset_q, t;
	logic mode_reject, ramp_enable_q, jerk_limited_q, speed_limit_en_q;
	logic field_weak_en_q, position_preset_pulse_q, limit_fault_q;
	logic block_detected_q, drive_block_q, block_done_q;
	logic [7:0] codes [3] = '{`DMVT_MODE_PV, `DMVT_MODE_PT, `DMVT_MODE_HM};
	logic [15:0] prof [3] = '{16'h3, 16'h7, 16'h0};
	int fails = 0, check_count = 0, n, r;
	wire [2:0] hs = {status_bits_q[13], status_bits_q[12], status_bits_q[10]};

	always #2 clock = ~clock;

	// Short ms tick and slope base keep the run to a few thousand cycles
	dmvt_top #(.MS_CYCLES(10), .CLK_HZ(1000)) u_dmvt_top (.*);
	dmvt_host u_dmvt_host (.*);

	// ==========================================
	// Helpers
	task automatic wt(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : wt

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic complete_run;
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	function automatic logic [31:0] exp_vel(input logic signed [31:0] v,
		input logic p);
		logic signed [31:0] m;
		m = $signed(vel_max);
		v = p ? -v : v;
		if (v > m) v = m;
		else if (v < -m) v = -m;
		return v;
	endfunction : exp_vel

	initial begin
		wt(20000);
		fails++;
		complete_run;
	end

	// ==========================================
	// Main sequence
	initial begin
		r = $urandom(32'h8e8a1ff8);
		wt(10);
		@(posedge clock);
		rstn <= 1'b1;
		wt(1);
		chk(active_mode_q, 32'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			want_mode <= codes[i];
			wt(4);
			chk(active_mode_q, codes[i]);
			chk(mode_reject, 1'b0);
		end
		@(posedge clock);
		want_mode <= 8'h07 + 8'($urandom % 200);
		wt(4);
		chk(mode_reject, 1'b1);
		chk(active_mode_q, `DMVT_MODE_HM);
		@(posedge clock);
		want_mode <= `DMVT_MODE_PV;
		oper_enabled <= 1'b1;
		vel_max <= 32'h3e8;
		// Range is wider than the limit so both clamps can be hit
		for (int i = 0; i < 6; i++) begin
			t = $signed($urandom % 2400) - 1200;
			@(posedge clock);
			target_vel <= t;
			polarity <= {1'($urandom), i[0], 6'($urandom)};
			wt(4);
			chk(vel_ramp_target_q, exp_vel(t, polarity[6]));
		end
		chk(ramp_enable_q, 1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			profile_type <= prof[i];
			wt(3);
			chk(jerk_limited_q, prof[i] != 16'h0);
		end
		@(posedge clock);
		vel_window <= 32'ha;
		vel_window_time <= 16'h2;
		vel_demand <= 32'sh64;
		vel_actual <= 32'sh74;
		wt(5);
		chk(status_bits_q[10], 1'b0);
		@(posedge clock);
		vel_actual <= 32'sh5a + $signed($urandom % 21);
		wt(7);
		chk(status_bits_q[10], 1'b0);
		wt(18);
		chk(status_bits_q[10], 1'b1);
		@(posedge clock);
		vel_actual <= 32'sh6f;
		wt(5);
		chk(status_bits_q[10], 1'b0);
		@(posedge clock);
		want_mode <= `DMVT_MODE_PT;
		vel_actual <= 32'sh5;
		torque_max <= 16'h28;
		torque_slope <= 32'h3e8;
		target_torque <= 16'sh64;
		torque_actual <= 16'sh28;
		torque_window <= 16'h2;
		torque_window_time <= 16'h1;
		wt(22);
		chk(torque_demand_q <= 16'sh16, 1'b1);
		chk(speed_limit_en_q & field_weak_en_q, 1'b1);
		wt(60);
		chk(torque_demand_q, 32'h28);
		chk(status_bits_q[10], 1'b1);
		@(posedge clock);
		torque_actual <= 16'sh20;
		submode <= 32'h20;
		wt(5);
		chk(status_bits_q[10], 1'b0);
		chk(speed_limit_en_q | field_weak_en_q, 1'b0);
		@(posedge clock);
		want_halt <= 1'b1;
		wt(60);
		chk(torque_demand_q, 32'h0);
		chk(status_bits_q[10], 1'b0);
		@(posedge clock);
		vel_actual <= '0;
		wt(4);
		chk(status_bits_q[10], 1'b1);
		@(posedge clock);
		want_halt <= 1'b0;
		wt(60);
		chk(torque_demand_q, 32'h28);
		@(posedge clock);
		torque_max <= 16'h5dc;
		target_torque <= 16'sh44c;
		wt(1200);
		chk(torque_demand_q, 32'h3e8);
		@(posedge clock);
		peak_duration <= 16'h1;
		peak_torque <= 16'h41a;
		wt(150);
		chk(torque_demand_q, 32'h41a);
		@(posedge clock);
		want_mode <= `DMVT_MODE_HM;
		home_switch_speed <= $urandom;
		home_index_speed <= $urandom;
		home_accel <= $urandom;
		home_offset <= $urandom;
		wt(4);
		chk(home_speed_q, home_switch_speed);
		chk(home_accel_q, home_accel);
		chk(hs, 3'h1);
		@(posedge clock);
		search_index <= 1'b1;
		want_home <= 1'b1;
		wt(4);
		chk(home_speed_q, home_index_speed);
		chk(hs, 3'h0);
		@(posedge clock);
		block_min_current <= 16'h64;
		block_detect_time <= 16'h3;
		block_period <= 16'h2;
		current_actual <= 16'h65;
		n = 0;
		while (block_detected_q !== 1'b1 && n < 60) begin
			wt(1);
			n++;
		end
		chk(n >= 20 && n <= 36, 1'b1);
		chk(drive_block_q, 1'b1);
		n = 0;
		while (block_done_q !== 1'b1 && n < 60) begin
			wt(1);
			n++;
		end
		chk(n >= 10 && n <= 23, 1'b1);
		@(posedge clock);
		current_actual <= '0;
		home_found <= 1'b1;
		n = 0;
		while (position_preset_pulse_q !== 1'b1 && n < 10) begin
			wt(1);
			n++;
		end
		chk(position_preset_pulse_q, 1'b1);
		chk(position_preset_q, home_offset);
		wt(1);
		chk(position_preset_pulse_q, 1'b0);
		wt(1);
		chk(hs, 3'h2);
		@(posedge clock);
		home_found <= 1'b0;
		home_at_target <= 1'b1;
		wt(4);
		chk(hs, 3'h3);
		@(posedge clock);
		want_home <= 1'b0;
		home_at_target <= 1'b0;
		wt(3);
		@(posedge clock);
		want_home <= 1'b1;
		wt(4);
		chk(hs, 3'h0);
		@(posedge clock);
		want_home <= 1'b0;
		wt(4);
		chk(hs, 3'h1);
		@(posedge clock);
		want_home <= 1'b1;
		vel_actual <= 32'sh7;
		homing_error <= 1'b1;
		wt(5);
		chk(hs, 3'h4);
		@(posedge clock);
		vel_actual <= '0;
		wt(4);
		chk(hs, 3'h5);
		@(posedge clock);
		homing_error <= 1'b0;
		tol_band <= 32'h32;
		limit_pos_pin <= 1'b1;
		wt(8);
		@(posedge clock);
		position_actual <= 32'sh32;
		wt(5);
		chk(limit_fault_q, 1'b0);
		@(posedge clock);
		position_actual <= 32'sh33;
		wt(4);
		chk(limit_fault_q, 1'b1);
		chk(ramp_enable_q, 1'b0);
		@(posedge clock);
		limit_pos_pin <= 1'b0;
		wt(8);
		chk(limit_fault_q, 1'b1);
		@(posedge clock);
		fault_reset <= 1'b1;
		wt(3);
		chk(limit_fault_q, 1'b0);
		@(posedge clock);
		fault_reset <= 1'b0;
		limit_neg_pin <= 1'b1;
		wt(8);
		@(posedge clock);
		position_actual <= 32'sh0;
		wt(4);
		chk(limit_fault_q, 1'b1);
		complete_run;
	end
endmodule : dmvt_top_tb
`default_nettype wire
